/* core/scpm_clk_ctrl.v */
// Summary of operation
// - select field picks fH, fH/2..fH/64, subclock
// - fast source bit picks RC or crystal
// - slow source bit picks slow RC or crystal
// - fast mode runs CPU from divided fH
// - slow mode, fH follows its enable bit
// - halt, keep bits 00 enters sleep
// - halt, keep bits 01 keeps subclock only
// - halt, keep bits 11 keeps both oscillators
// - halt, keep bits 10 keeps fast only
// - fast keep bit holds fH when halted
// - slow keep bit holds subclock when halted
// - switch completes after four system ticks plus alignment
// - RC frequency codes 8, 12, 16, 8 MHz
// - new RC frequency applies after stable flag
// - RC enable clears flag, sets when stable
// - RC enable resets to one, runs
// - unimplemented bits read as zero, except slow crystal bit 2, which reads one
// - fast crystal enable clears then sets flag
// - slow crystal enable clears then sets flag
`timescale 1ns/1ps
`include "scpm_consts.vh"

// Stability tracker: flag drops when the oscillator starts or restarts
// and rises after a number of its own ticks.
module scpm_stab #(
   parameter COUNT = 16
) (
   input  wire clk,       // System clock
   input  wire rst_n,     // Synchronised reset
   input  wire osc_on,    // Oscillator running
   input  wire restart,   // Force a new settling period
   input  wire tick,      // One oscillator tick
   output reg  stable_r   // Oscillator stable
);
   reg [15:0] cnt_r;
   reg        on_d_r;

   // A rising enable or restart restarts the count from zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r    <= 16'h0000;
         on_d_r   <= 1'b0;
         stable_r <= 1'b0;
      end else begin
         on_d_r <= osc_on;
         if (!osc_on || restart || !on_d_r) begin
            cnt_r    <= 16'h0000;
            stable_r <= 1'b0;
         end else if (tick && !stable_r) begin
            if (cnt_r == COUNT[15:0] - 16'h0001)
               stable_r <= 1'b1;
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule

module scpm_clk_ctrl #(
   parameter STAB_RC  = `SCPM_STAB_RC,
   parameter STAB_FXT = `SCPM_STAB_FXT,
   parameter STAB_SXT = `SCPM_STAB_SXT
) (
   input  wire        ref_clk,        // 50 MHz system clock
   input  wire        rst_n,          // Async reset, active low
   input  wire        wb_cyc_i,       // Wishbone cycle
   input  wire        wb_stb_i,       // Wishbone strobe
   input  wire        wb_we_i,        // Wishbone write
   input  wire [3:0]  wb_adr_i,       // Byte address
   input  wire [3:0]  wb_sel_i,       // Byte lanes
   input  wire [31:0] wb_dat_i,       // Write data
   output reg  [31:0] wb_dat_o,       // Read data
   output reg         wb_ack_o,       // Acknowledge
   input  wire        halt_i,         // Halt instruction pulse
   input  wire        wake_i,         // Wake-up event pulse
   input  wire        wdt_en_i,       // Watchdog enabled
   input  wire        rc_tick_i,      // Internal fast RC tick
   input  wire        fxt_tick_i,     // Fast crystal tick
   input  wire        src_tick_i,     // Internal slow RC tick
   input  wire        sxt_tick_i,     // Slow crystal tick
   output reg         cpu_clk_en_o,   // CPU clock gate pulse
   output reg         sys_clk_en_o,   // System clock pulse (run modes)
   output reg         fast_clk_en_o,  // fH pulse to peripherals
   output reg         sub_clk_en_o,   // Subclock pulse to peripherals
   output reg         slow_rc_clk_o,  // Slow RC pulse (watchdog)
   output reg         rc_osc_on_o,    // Internal fast RC enable
   output reg  [1:0]  rc_freq_o,      // Applied RC frequency code
   output reg         fxt_osc_on_o,   // Fast crystal enable
   output reg         fxt_mode_o,     // Fast crystal drive mode
   output reg         sxt_osc_on_o,   // Slow crystal enable
   output reg         src_osc_on_o,   // Internal slow RC enable
   output reg  [2:0]  mode_o          // Current operating mode
);
   // Operating modes
   localparam [2:0] M_FAST  = 3'h0;
   localparam [2:0] M_SLOW  = 3'h1;
   localparam [2:0] M_SLEEP = 3'h2;
   localparam [2:0] M_IDLE_SLOW_ONLY = 3'h3;
   localparam [2:0] M_IDLE_BOTH_CLOCKS = 3'h4;
   localparam [2:0] M_IDLE_FAST_ONLY = 3'h5;

   // Clock switch sequencer states
   localparam [1:0] S_IDLE  = 2'h0;
   localparam [1:0] S_WAIT  = 2'h1;
   localparam [1:0] S_ALIGN = 2'h2;

   reg        rs1_r, rs2_r;
   wire       rst_s_n = rs2_r;

   reg  [7:0] sys_r, rc_r, fxt_r, sxt_r;
   reg  [4:0] app_r;            // Applied {sel, fsrc, ssrc}
   reg  [1:0] sw_st_r;
   reg  [2:0] sw_cnt_r;
   reg  [2:0] mode_r, mode_nxt;
   reg  [5:0] div_r;
   reg        rc_en_d_r;
   reg  [1:0] rc_freq_d_r;
   wire       rc_stab, fxt_stab, sxt_stab;

   // Reset released through two flops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end

   wire [2:0] sel      = sys_r[`SCPM_SYS_SEL_HI:`SCPM_SYS_SEL_LO];
   wire       keep_f   = sys_r[`SCPM_SYS_KEEPF];
   wire       keep_s   = sys_r[`SCPM_SYS_KEEPS];
   wire       running  = (mode_r == M_FAST) || (mode_r == M_SLOW);
   wire [4:0] want     = {sel, sys_r[`SCPM_SYS_FSRC], sys_r[`SCPM_SYS_SSRC]};
   wire       app_sub  = (app_r[4:2] == `SCPM_SEL_SUB);

   // Oscillator demand per mode
   wire fh_need  = (running && !app_sub) || (!running && keep_f);
   wire fh_allow = running || keep_f;
   wire sub_need = running || keep_s;
   wire rc_on    = (fh_need && !want[1]) || (fh_need && !app_r[1]) ||
                   (rc_r[`SCPM_RC_EN] && fh_allow);
   wire fxt_on   = (fh_need && want[1]) || (fh_need && app_r[1]) ||
                   (fxt_r[`SCPM_XT_EN] && fh_allow);
   wire sxt_on   = sub_need && (want[0] || app_r[0] || sxt_r[`SCPM_XT_EN]);
   wire src_on   = !(mode_r == M_SLEEP && !wdt_en_i);

   // Ticks of the sources as they reach the clock tree
   wire rc_t     = rc_tick_i && rc_on && rc_stab;
   wire fxt_t    = fxt_tick_i && fxt_on;
   wire sxt_t    = sxt_tick_i && sxt_on;
   wire src_t    = src_tick_i && src_on;

   // Settling trackers; frequency change restarts the RC one
   wire rc_fchg  = rc_r[`SCPM_RC_FREQ_HI:`SCPM_RC_FREQ_LO] != rc_freq_d_r;

   scpm_stab #(.COUNT(STAB_RC)) u_rc_stab (
      .clk      (ref_clk),
      .rst_n    (rst_s_n),
      .osc_on   (rc_on),
      .restart  (rc_fchg || (rc_r[`SCPM_RC_EN] && !rc_en_d_r)),
      .tick     (rc_tick_i),
      .stable_r (rc_stab)
   );
   scpm_stab #(.COUNT(STAB_FXT)) u_fxt_stab (
      .clk      (ref_clk),
      .rst_n    (rst_s_n),
      .osc_on   (fxt_on),
      .restart  (1'b0),
      .tick     (fxt_tick_i),
      .stable_r (fxt_stab)
   );
   scpm_stab #(.COUNT(STAB_SXT)) u_sxt_stab (
      .clk      (ref_clk),
      .rst_n    (rst_s_n),
      .osc_on   (sxt_on),
      .restart  (1'b0),
      .tick     (sxt_tick_i),
      .stable_r (sxt_stab)
   );

   // Tick of the system clock for a given selection
   function tick_of;
      input [4:0] s;
      input [5:0] d;
      input       rt, ft, st, lt;
      reg         fh;
      begin
         fh = s[1] ? ft : rt;
         case (s[4:2])
            3'h0:    tick_of = fh;
            3'h1:    tick_of = fh && d[0];
            3'h2:    tick_of = fh && (&d[1:0]);
            3'h3:    tick_of = fh && (&d[2:0]);
            3'h4:    tick_of = fh && (&d[3:0]);
            3'h5:    tick_of = fh && (&d[4:0]);
            3'h6:    tick_of = fh && (&d[5:0]);
            default: tick_of = s[0] ? st : lt;
         endcase
      end
   endfunction

   wire fh_t    = app_r[1] ? fxt_t : rc_t;
   wire cur_t   = tick_of(app_r, div_r, rc_t, fxt_t, sxt_t, src_t);
   wire tar_t   = tick_of(want, div_r, rc_t, fxt_t, sxt_t, src_t);

   // fH divider; counts only on fH ticks so divided pulses stay whole
   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n)
         div_r <= 6'h00;
      else if (fh_t)
         div_r <= div_r + 6'h01;
   end

   // Clock switch: four ticks of the current clock, then hand over on a
   // target tick, so no shortened period is ever issued
   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sw_st_r  <= S_IDLE;
         sw_cnt_r <= 3'h0;
         app_r    <= 5'h00;
      end else begin
         case (sw_st_r)
            S_IDLE: begin
               sw_cnt_r <= 3'h0;
               if (want != app_r)
                  sw_st_r <= S_WAIT;
            end
            S_WAIT: begin
               if (cur_t || !running) begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
                  if (sw_cnt_r == `SCPM_SW_SYS_TICKS - 3'h1)
                     sw_st_r <= S_ALIGN;
               end
            end
            S_ALIGN: begin
               if (tar_t) begin
                  app_r   <= want;
                  sw_st_r <= S_IDLE;
               end
            end
            default: sw_st_r <= S_IDLE;
         endcase
      end
   end

   // Mode sequencing: halt picks the power-down mode from the keep bits
   always @* begin
      mode_nxt = mode_r;
      case (mode_r)
         M_FAST, M_SLOW: begin
            if (halt_i) begin
               case ({keep_f, keep_s})
                  2'b00:   mode_nxt = M_SLEEP;
                  2'b01:   mode_nxt = M_IDLE_SLOW_ONLY;
                  2'b11:   mode_nxt = M_IDLE_BOTH_CLOCKS;
                  default: mode_nxt = M_IDLE_FAST_ONLY;
               endcase
            end else begin
               mode_nxt = app_sub ? M_SLOW : M_FAST;
            end
         end
         M_SLEEP, M_IDLE_SLOW_ONLY, M_IDLE_BOTH_CLOCKS, M_IDLE_FAST_ONLY: begin
            if (wake_i)
               mode_nxt = app_sub ? M_SLOW : M_FAST;
         end
         default: mode_nxt = M_FAST;
      endcase
   end

   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n)
         mode_r <= M_FAST;
      else
         mode_r <= mode_nxt;
   end

   // Register file; the bus answers every address with one-cycle ack
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sys_r       <= `SCPM_RST_SYSCLK;
         rc_r        <= `SCPM_RST_RCCTL;
         fxt_r       <= `SCPM_RST_FXTAL;
         sxt_r       <= `SCPM_RST_SXTAL;
         rc_en_d_r   <= 1'b1;
         rc_freq_d_r <= `SCPM_RC_8M;
      end else begin
         rc_en_d_r   <= rc_r[`SCPM_RC_EN];
         rc_freq_d_r <= rc_r[`SCPM_RC_FREQ_HI:`SCPM_RC_FREQ_LO];
         if (bus_wr) begin
            case (wb_adr_i)
               `SCPM_OFS_SYSCLK: sys_r <= wb_dat_i[7:0] & `SCPM_SYS_WMASK;
               `SCPM_OFS_RCCTL:  rc_r  <= {4'h0, wb_dat_i[3:2], 1'b0, wb_dat_i[0]};
               `SCPM_OFS_FXTAL:  fxt_r <= {5'h00, wb_dat_i[2], 1'b0, wb_dat_i[0]};
               `SCPM_OFS_SXTAL:  sxt_r <= {7'h00, wb_dat_i[0]};
               default:          sys_r <= sys_r;
            endcase
         end
      end
   end

   // Read mux; flags come live from the trackers, upper bits are zero
   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            case (wb_adr_i)
               `SCPM_OFS_SYSCLK: wb_dat_o <= {24'h000000, sys_r};
               `SCPM_OFS_RCCTL:  wb_dat_o <= {28'h0000000, rc_r[3:2], rc_stab,
                                              rc_r[0]};
               `SCPM_OFS_FXTAL:  wb_dat_o <= {29'h0000000, fxt_r[2], fxt_stab,
                                              fxt_r[0]};
               `SCPM_OFS_SXTAL:  wb_dat_o <= {29'h0000000, 1'b1, sxt_stab,
                                              sxt_r[0]};
               default:          wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Registered clock gates and oscillator controls
   always @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         cpu_clk_en_o  <= 1'b0;
         sys_clk_en_o  <= 1'b0;
         fast_clk_en_o <= 1'b0;
         sub_clk_en_o  <= 1'b0;
         slow_rc_clk_o <= 1'b0;
         rc_osc_on_o   <= 1'b1;
         rc_freq_o     <= `SCPM_RC_8M;
         fxt_osc_on_o  <= 1'b0;
         fxt_mode_o    <= 1'b0;
         sxt_osc_on_o  <= 1'b0;
         src_osc_on_o  <= 1'b1;
         mode_o        <= M_FAST;
      end else begin
         cpu_clk_en_o  <= cur_t && running && !halt_i;
         sys_clk_en_o  <= cur_t && running;
         fast_clk_en_o <= fh_t && fh_allow;
         sub_clk_en_o  <= (app_r[0] ? sxt_t : src_t) && sub_need;
         slow_rc_clk_o <= src_t;
         rc_osc_on_o   <= rc_on;
         fxt_osc_on_o  <= fxt_on;
         fxt_mode_o    <= fxt_r[`SCPM_XT_MODE];
         sxt_osc_on_o  <= sxt_on;
         src_osc_on_o  <= src_on;
         mode_o        <= mode_r;
         // Code 3 folds onto 8 MHz; a new code waits for the flag
         if (rc_stab && !rc_fchg) begin
            case (rc_r[`SCPM_RC_FREQ_HI:`SCPM_RC_FREQ_LO])
               `SCPM_RC_12M: rc_freq_o <= `SCPM_RC_12M;
               `SCPM_RC_16M: rc_freq_o <= `SCPM_RC_16M;
               default:      rc_freq_o <= `SCPM_RC_8M;
            endcase
         end
      end
   end
endmodule

/* inc/scpm_consts.vh */
`ifndef SCPM_CONSTS_VH
`define SCPM_CONSTS_VH

// Register byte offsets on the bus
`define SCPM_OFS_SYSCLK   4'h0
`define SCPM_OFS_RCCTL    4'h4
`define SCPM_OFS_FXTAL    4'h8
`define SCPM_OFS_SXTAL    4'hC

// System clock control fields
`define SCPM_SYS_SEL_HI   7
`define SCPM_SYS_SEL_LO   5
`define SCPM_SYS_FSRC     3
`define SCPM_SYS_SSRC     2
`define SCPM_SYS_KEEPF    1
`define SCPM_SYS_KEEPS    0
`define SCPM_SYS_WMASK    8'hEF

// Internal RC control fields
`define SCPM_RC_FREQ_HI   3
`define SCPM_RC_FREQ_LO   2
`define SCPM_RC_FLAG      1
`define SCPM_RC_EN        0

// Crystal control fields
`define SCPM_XT_MODE      2
`define SCPM_XT_FLAG      1
`define SCPM_XT_EN        0

// Reset values
`define SCPM_RST_SYSCLK   8'h00
`define SCPM_RST_RCCTL    8'h01
`define SCPM_RST_FXTAL    8'h00
`define SCPM_RST_SXTAL    8'h00

// Encodings
`define SCPM_SEL_SUB      3'h7
`define SCPM_RC_8M        2'h0
`define SCPM_RC_12M       2'h1
`define SCPM_RC_16M       2'h2

// Switch delay: whole periods of the current system clock
`define SCPM_SW_SYS_TICKS 3'h4

// Default stabilisation counts, in oscillator ticks
`define SCPM_STAB_RC      16
`define SCPM_STAB_FXT     64
`define SCPM_STAB_SXT     32

`endif

/* bench/scpm_osc_model.sv */
`timescale 1ns/1ps
// One oscillator: a tick every P cycles while enabled, silent when off.
// Phase restarts on enable, as a real oscillator starts from rest.
module scpm_osc_model #(
   parameter P = 3            // Period in ref_clk cycles
) (
   input  wire ref_clk,       // Bench clock
   input  wire rst_n,         // Reset, low
   input  wire on,            // Oscillator enable
   output reg  tick           // One-cycle tick
);
   reg [7:0] cnt_r;
   // Period counter, held cleared while disabled
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         tick <= 1'b0;
      end else if (!on || cnt_r == P - 1) begin
         cnt_r <= 8'h00;
         tick <= on;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule

/* bench/scpm_asserts.sv */
`timescale 1ns/1ps
// Port checks; keep bits are shadowed from taken bus writes
module scpm_asserts (
   input wire        ref_clk,       // Clock
   input wire        rst_n,         // Reset, low
   input wire        wb_cyc_i,      // Cycle
   input wire        wb_stb_i,      // Strobe
   input wire        wb_we_i,       // Write
   input wire [3:0]  wb_adr_i,      // Address
   input wire [3:0]  wb_sel_i,      // Lanes
   input wire [31:0] wb_dat_i,      // Write data
   input wire [31:0] wb_dat_o,      // Read data
   input wire        wb_ack_o,      // Ack
   input wire        halt_i,        // Halt
   input wire        wdt_en_i,      // Watchdog on
   input wire        cpu_clk_en_o,  // CPU tick
   input wire        fast_clk_en_o, // Fast tick
   input wire        sub_clk_en_o,  // Subclock tick
   input wire        src_osc_on_o,  // Slow RC on
   input wire [2:0]  mode_o         // Mode
);
   reg  [1:0] keep_r;
   wire [2:0] exp_mode;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Shadow of the keep bits at the edge a write is taken
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         keep_r <= 2'h0;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 4'h0)
         keep_r <= wb_dat_i[1:0];
   end
   assign exp_mode = (keep_r == 2'h0) ? 3'h2 : (keep_r == 2'h1) ? 3'h3 :
                     (keep_r == 2'h3) ? 3'h4 : 3'h5;
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_unused_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000
      && !(wb_adr_i == 4'h0 && wb_dat_o[4]) && !(wb_adr_i == 4'h4 && wb_dat_o[7:4] != 4'h0))
      else $error("unused bits not zero");
   chk_halt_entry: assert property (halt_i && mode_o <= 3'h1
      |-> ##2 mode_o == exp_mode) else $error("wrong halted mode");
   chk_halt_cpu: assert property (mode_o >= 3'h2 && $past(mode_o) >= 3'h2 |-> !cpu_clk_en_o)
      else $error("CPU ticks while halted");
   chk_sleep_quiet: assert property (mode_o == 3'h2 && $past(mode_o) == 3'h2
      |-> !fast_clk_en_o && !sub_clk_en_o) else $error("clock runs in sleep");
   chk_idle_slow_only_nofast: assert property (mode_o == 3'h3 && $past(mode_o) == 3'h3
      |-> !fast_clk_en_o) else $error("fast clock in idle_slow_only");
   chk_idle_fast_only_nosub: assert property (mode_o == 3'h5 && $past(mode_o) == 3'h5
      |-> !sub_clk_en_o) else $error("subclock in idle_fast_only");
   chk_run_slow_rc: assert property (mode_o <= 3'h1 && $past(mode_o) <= 3'h1
      |-> src_osc_on_o) else $error("slow RC off while running");
   cover property (mode_o == 3'h4);
   cover property (mode_o == 3'h1);
   cover property (halt_i && mode_o == 3'h0);
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   reg         ref_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         wb_cyc_i = 1'b0;
   reg         wb_stb_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [3:0]  wb_adr_i = 4'h0;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [31:0] wb_dat_i = 32'h00000000;
   reg         halt_i = 1'b0;
   reg         wake_i = 1'b0;
   reg         wdt_en_i = 1'b0;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, rc_tick, fxt_tick, src_tick, sxt_tick, cpu_clk_en_o, sys_clk_en_o;
   wire        fast_clk_en_o, sub_clk_en_o, rc_osc_on_o, fxt_osc_on_o, sxt_osc_on_o;
   wire        src_osc_on_o, slow_rc_clk_o, fxt_mode_o;
   wire [1:0]  rc_freq_o;
   wire [2:0]  mode_o;
   integer     n_fail = 0;
   integer     samples_checked = 0;
   integer     k, i, f, s, t, g;
   reg  [7:0]  q;
   reg  [3:0]  lane = 4'h1;
   reg         wdt;
   always #10 ref_clk = ~ref_clk;
   // Small settling counts keep the run short
   scpm_clk_ctrl #(.STAB_RC(8), .STAB_FXT(8), .STAB_SXT(8)) scpm_clk_ctrl_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halt_i(halt_i), .wake_i(wake_i),
      .wdt_en_i(wdt_en_i), .rc_tick_i(rc_tick), .fxt_tick_i(fxt_tick), .src_tick_i(src_tick),
      .sxt_tick_i(sxt_tick), .cpu_clk_en_o(cpu_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
      .fast_clk_en_o(fast_clk_en_o), .sub_clk_en_o(sub_clk_en_o),
      .slow_rc_clk_o(slow_rc_clk_o),
      .rc_osc_on_o(rc_osc_on_o), .rc_freq_o(rc_freq_o), .fxt_osc_on_o(fxt_osc_on_o),
      .fxt_mode_o(fxt_mode_o), .sxt_osc_on_o(sxt_osc_on_o), .src_osc_on_o(src_osc_on_o),
      .mode_o(mode_o));
   // Oscillators: fast RC 3, fast crystal 4, slow RC 7, slow crystal 9 cycles
   scpm_osc_model #(.P(3)) rc_osc (.ref_clk(ref_clk), .rst_n(rst_n),
      .on(rc_osc_on_o), .tick(rc_tick));
   scpm_osc_model #(.P(4)) fx_osc (.ref_clk(ref_clk), .rst_n(rst_n),
      .on(fxt_osc_on_o), .tick(fxt_tick));
   scpm_osc_model #(.P(7)) sr_osc (.ref_clk(ref_clk), .rst_n(rst_n),
      .on(src_osc_on_o), .tick(src_tick));
   scpm_osc_model #(.P(9)) sx_osc (.ref_clk(ref_clk), .rst_n(rst_n),
      .on(sxt_osc_on_o), .tick(sxt_tick));

   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Classic single cycle; held until ack is sampled high
   task bus(input w, input [3:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_sel_i <= lane;
         wb_dat_i <= {24'h000000, d};
         i = 0;
         @(posedge ref_clk);
         while (wb_ack_o !== 1'b1 && i < 50) begin
            @(posedge ref_clk);
            i = i + 1;
         end
         q = wb_dat_o[7:0];
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         check(i < 50, 1'b1);
      end
   endtask
   task rd(input [3:0] a, input [7:0] e, input [7:0] m);
      begin
         bus(1'b0, a, 8'h00);
         check(q & m, e & m);
      end
   endtask
   task poll(input [3:0] a);
      begin
         q = 8'h00;
         for (t = 0; t < 40 && q[1] !== 1'b1; t = t + 1)
            bus(1'b0, a, 8'h00);
         check(q[1], 1'b1);
      end
   endtask
   // Counts fast, system and subclock ticks over n cycles
   task count(input integer n);
      begin
         f = 0;
         s = 0;
         t = 0;
         g = 0;
         repeat (n) begin
            @(posedge ref_clk);
            f = f + (fast_clk_en_o === 1'b1);
            g = g + (slow_rc_clk_o === 1'b1);
            s = s + (sys_clk_en_o === 1'b1);
            t = t + (sub_clk_en_o === 1'b1);
         end
      end
   endtask
   // Writes a selection, then times the handover seen on mode_o
   task sw(input [7:0] v, input [2:0] m, input integer lim);
      begin
         bus(1'b1, 4'h0, v);
         s = 0;
         for (t = 0; t < 200 && mode_o !== m; t = t + 1) begin
            @(posedge ref_clk);
            s = s + (sys_clk_en_o === 1'b1);
         end
         check(s >= 3 && t <= lim, 1'b1);
      end
   endtask
   task pulse(input h);
      begin
         @(posedge ref_clk);
         halt_i <= h;
         wake_i <= !h;
         @(posedge ref_clk);
         halt_i <= 1'b0;
         wake_i <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   function [1:0] rcf(input integer c);
      rcf = (c == 3) ? 2'h0 : c[1:0];
   endfunction
   function [2:0] mt(input integer c);
      mt = (c == 0) ? 3'h2 : (c == 1) ? 3'h3 : (c == 3) ? 3'h4 : 3'h5;
   endfunction
   task give_verdict;
      begin
         if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // A hang ends the run as a failure
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail = n_fail + 1;
      give_verdict;
   end
   initial begin
      q = $urandom(32'h5DCA);
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(rc_osc_on_o, 1'b1);
      check(rc_freq_o, 2'h0);
      rd(4'h0, 8'h00, 8'hFF);
      rd(4'h4, 8'h01, 8'hFD);
      rd(4'h8, 8'h00, 8'hFF);
      rd(4'hC, 8'h04, 8'hFF);
      q = $urandom;
      bus(1'b1, 4'h2, q);
      rd(4'h2, 8'h00, 8'hFF);
      bus(1'b1, 4'h0, 8'h10);
      rd(4'h0, 8'h00, 8'hFF);
      // Lane 0 off: the whole write must be dropped
      k = $urandom;
      lane = {k[3:1], 1'b0};
      bus(1'b1, 4'h0, 8'hE3);
      lane = 4'h1;
      rd(4'h0, 8'h00, 8'hFF);
      bus(1'b1, 4'h4, 8'hF1);
      rd(4'h4, 8'h01, 8'hFD);
      bus(1'b1, 4'h8, 8'h05);
      rd(4'h8, 8'h05, 8'hFF);
      check(fxt_mode_o, 1'b1);
      check(fxt_osc_on_o, 1'b1);
      poll(4'h8);
      bus(1'b1, 4'hC, 8'h01);
      rd(4'hC, 8'h05, 8'hFF);
      check(sxt_osc_on_o, 1'b1);
      poll(4'hC);
      // Frequency codes apply only once the flag is back up
      for (k = 1; k < 4; k = k + 1) begin
         bus(1'b1, 4'h4, {4'h0, k[1:0], 2'b01});
         check(rc_freq_o, rcf(k - 1));
         rd(4'h4, {4'h0, k[1:0], 2'b01}, 8'hFF);
         poll(4'h4);
         check(rc_freq_o, rcf(k));
      end
      bus(1'b1, 4'h4, 8'h01); // back to the configured frequency
      poll(4'h4);
      sw(8'hE0, 3'h1, 29);
      count(60);
      check(f > 0 && t > 0, 1'b1);
      bus(1'b1, 4'h4, 8'h00);
      repeat (4) @(posedge ref_clk);
      check(rc_osc_on_o, 1'b0);
      bus(1'b1, 4'h4, 8'h01);
      poll(4'h4);
      sw(8'h00, 3'h0, 45);
      for (k = 0; k < 7; k = k + 1) begin
         bus(1'b1, 4'h0, {k[2:0], 5'h00});
         repeat (16 << k) @(posedge ref_clk);
         count(768);
         check((s << k) + (1 << k) >= f && (s << k) <= f + (1 << k), 1'b1);
         check(f > 200 && t > 0, 1'b1);
      end
      // Fast crystal as fH, period 4: 192 ticks in 768 cycles
      bus(1'b1, 4'h0, 8'h08);
      repeat (1200) @(posedge ref_clk);
      count(768);
      check(f >= 191 && f <= 193, 1'b1);
      // Slow crystal feeds the subclock from here on
      bus(1'b1, 4'h0, 8'h04);
      repeat (800) @(posedge ref_clk);
      for (k = 0; k < 4; k = k + 1) begin
         wdt = $urandom % 2;
         wdt_en_i <= wdt;
         bus(1'b1, 4'h0, k[7:0] | 8'h04);
         pulse(1'b1);
         check(mode_o, mt(k));
         check(rc_osc_on_o, k[1]);
         check(src_osc_on_o, k != 0 || wdt);
         check(fxt_osc_on_o, k[1]);
         check(sxt_osc_on_o, k[0]);
         count(40);
         check(g > 0, k != 0 || wdt);
         check(f > 0, k[1]);
         check(t > 0, k[0]);
         pulse(1'b0);
         check(mode_o, 3'h0);
      end
      give_verdict;
   end
endmodule

bind scpm_clk_ctrl scpm_asserts scpm_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .halt_i(halt_i), .wdt_en_i(wdt_en_i), .cpu_clk_en_o(cpu_clk_en_o),
   .fast_clk_en_o(fast_clk_en_o), .sub_clk_en_o(sub_clk_en_o),
   .src_osc_on_o(src_osc_on_o), .mode_o(mode_o));
